// ===== core/dac_regs_pkg.sv
`default_nettype none
package dac_regs_pkg;
  // sizes
  localparam int NUM_CH = 4;
  localparam int CODE_W = 16;
  localparam logic [5:0] FRAME_BITS = 6'h18;
  localparam logic [5:0] FRAME_PEC_BITS = 6'h20;

  // register group select, header bits 20..18
  localparam logic [2:0] DREG_CODE = 3'h0;
  localparam logic [2:0] DREG_GAIN = 3'h2;
  localparam logic [2:0] DREG_OFFSET = 3'h3;
  localparam logic [2:0] DREG_CLEAR = 3'h4;
  localparam logic [2:0] DREG_CONTROL = 3'h6;
  localparam logic [2:0] DREG_STATUS = 3'h7;

  // control register select, data bits 15..13 of a control access
  localparam logic [2:0] SUB_SLEW = 3'h0;
  localparam logic [2:0] SUB_MAIN = 3'h1;
  localparam logic [2:0] SUB_CHCTL = 3'h2;
  localparam logic [2:0] SUB_DCDC = 3'h3;
  localparam logic [2:0] SUB_SOFT = 3'h4;

  // software register keys in data bits 11..0, packet check enable in bit 12
  localparam logic [11:0] SOFT_RESET_KEY = 12'h555;
  localparam logic [11:0] SOFT_KICK_KEY = 12'h195;
  localparam int SOFT_PEC_BIT = 12;

  // reset values
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [15:0] GAIN_RESET = 16'hFFFF;
  localparam logic [15:0] OFFSET_RESET = 16'h8000;
  localparam logic [15:0] CLEAR_RESET = 16'h0000;
  localparam logic [12:0] SLEW_RESET = 13'h0000;
  localparam logic [2:0] RANGE_0_5V = 3'h0;

  // one serial frame, msb first
  typedef struct packed {
    logic rw;
    logic [1:0] dev_addr;
    logic [2:0] dreg;
    logic [1:0] ch;
    logic [15:0] data;
  } frame_s;

  // per channel control, bits 8..0 of the data field
  typedef struct packed {
    logic converter_power_bit;
    logic output_drive_enable;
    logic int_enable;
    logic overrange;
    logic clear_enable;
    logic ext_sense;
    logic [2:0] range;
  } ch_ctl_s;

  // main control, bits 5..0
  typedef struct packed {
    logic [1:0] wd_time;
    logic wd_enable;
    logic all_power;
    logic all_outputs;
    logic status_readback;
  } main_ctl_s;

  // boost converter control, bits 5..0
  typedef struct packed {
    logic [1:0] freq;
    logic [1:0] phase;
    logic [1:0] max_v;
  } dcdc_s;

  localparam ch_ctl_s CHCTL_RESET = '{default: 1'b0, range: RANGE_0_5V};
endpackage
`default_nettype wire

// ===== core/sync3.sv
`timescale 1ns/1ps
`default_nettype none
// three stage synchroniser; level moves once stages two and three agree
module sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // stage chain and per-bit agreement
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== core/serial_word_rx.sv
`timescale 1ns/1ps
`default_nettype none
// link side: shifts frames in on falling serial clock, readback out
module serial_word_rx
  import dac_regs_pkg::*;
(
  input wire logic sclk_link,
  input wire logic resetn,
  input wire logic frame_select_n,
  input wire logic sdin,
  input wire logic packet_check,
  input wire logic [23:0] readback,
  output logic [23:0] word,
  output logic word_toggle,
  output logic sdo
);
  logic [5:0] count;
  logic [30:0] shreg;
  logic [31:0] incoming;
  logic [5:0] needed;
  logic count_clear_n;

  assign incoming = {shreg, sdin};
  assign needed = packet_check ? FRAME_PEC_BITS : FRAME_BITS;
  // the frame's own select clears the counter, since the clock stops
  assign count_clear_n = resetn & ~frame_select_n;

  // bit counter, saturating
  always_ff @(negedge sclk_link or negedge count_clear_n) begin
    if (!count_clear_n) begin
      count <= '0;
    end else if (count != 6'h3F) begin
      count <= count + 6'h01;
    end
  end

  // shift in msb first, capture header plus data at frame length
  always_ff @(negedge sclk_link or negedge resetn) begin
    if (!resetn) begin
      shreg <= '0;
      word <= '0;
      word_toggle <= 1'b0;
    end else if (!frame_select_n) begin
      shreg <= incoming[30:0];
      if (count + 6'h01 == needed) begin
        word <= packet_check ? incoming[31:8] : incoming[23:0];
        word_toggle <= ~word_toggle;
      end
    end
  end

  // readback bit 23-n appears after falling edge n
  always_ff @(negedge sclk_link or negedge resetn) begin
    if (!resetn) begin
      sdo <= 1'b0;
    end else if (!frame_select_n && count < FRAME_BITS) begin
      sdo <= readback[5'(FRAME_BITS - 6'h01 - count)];
    end else begin
      sdo <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== core/quad_dac_regs.sv
`timescale 1ns/1ps
`default_nettype none
module quad_dac_regs
  import dac_regs_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic sclk_link,
  input wire logic frame_select_n,
  input wire logic sdin,
  input wire logic load_outputs_strobe_n,
  input wire logic clear_request,
  input wire logic [1:0] addr_pins,
  input wire logic [3:0] fault_pins,
  output logic sdo,
  output logic [dac_regs_pkg::NUM_CH-1:0][15:0] channel_output,
  output logic [dac_regs_pkg::NUM_CH-1:0][15:0] gain_trim,
  output logic [dac_regs_pkg::NUM_CH-1:0][15:0] offset_trim,
  output dac_regs_pkg::ch_ctl_s [dac_regs_pkg::NUM_CH-1:0] channel_control,
  output logic [dac_regs_pkg::NUM_CH-1:0][12:0] slew_rate,
  output logic [dac_regs_pkg::NUM_CH-1:0] drive_enable,
  output logic [dac_regs_pkg::NUM_CH-1:0] power_on,
  output logic [dac_regs_pkg::NUM_CH-1:0] calibrate_start,
  output dac_regs_pkg::main_ctl_s main_control,
  output dac_regs_pkg::dcdc_s dcdc_control,
  output logic watchdog_kick
);
  import dac_regs_pkg::*;

  logic [23:0] link_word;
  logic link_toggle;
  logic link_pec;
  logic [23:0] rb_word;
  logic [9:0] pins_sync;
  logic frame_n_s;
  logic load_outputs_strobe_n_s;
  logic clear_s;
  logic toggle_s;
  logic [1:0] addr_s;
  logic [3:0] fault_s;
  logic frame_prev;
  logic load_outputs_strobe_prev;
  logic clear_prev;
  logic toggle_seen;
  logic frame_end;
  logic word_new;
  logic length_error;
  logic clear_event;
  logic load_event;
  frame_s f;
  logic wr;
  logic rd;
  logic wr_code;
  logic wr_gain;
  logic wr_offset;
  logic wr_clear;
  logic wr_ctl;
  logic [2:0] sub;
  logic soft_hit;
  logic soft_rst;
  logic packet_check;
  logic length_flag;
  logic [15:0] status_word;
  logic [15:0] read_value;
  logic [NUM_CH-1:0][15:0] code_reg;
  logic [NUM_CH-1:0][15:0] clear_value;
  logic [NUM_CH-1:0] pending;

  // link domain: shifter and readback driver
  serial_word_rx rx (
    .sclk_link(sclk_link),
    .resetn(resetn),
    .frame_select_n(frame_select_n),
    .sdin(sdin),
    .packet_check(link_pec),
    .readback(rb_word),
    .word(link_word),
    .word_toggle(link_toggle),
    .sdo(sdo)
  );

  // packet check level into the link domain
  sync3 #(.WIDTH(1)) pec_sync (
    .clock(sclk_link),
    .resetn(resetn),
    .async_in(packet_check),
    .level(link_pec)
  );

  // pins and link toggle into the system domain; active-low pins enter inverted so reset matches idle high
  sync3 #(.WIDTH(10)) pin_sync (
    .clock(clock),
    .resetn(resetn),
    .async_in({link_toggle, fault_pins, addr_pins, clear_request, ~load_outputs_strobe_n, ~frame_select_n}),
    .level(pins_sync)
  );

  assign frame_n_s = ~pins_sync[0];
  assign load_outputs_strobe_n_s = ~pins_sync[1];
  assign clear_s = pins_sync[2];
  assign addr_s = pins_sync[4:3];
  assign fault_s = pins_sync[8:5];
  assign toggle_s = pins_sync[9];

  // edge history of synchronised levels
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      frame_prev <= 1'b1;
      load_outputs_strobe_prev <= 1'b1;
      clear_prev <= 1'b0;
      toggle_seen <= 1'b0;
    end else begin
      frame_prev <= frame_n_s;
      load_outputs_strobe_prev <= load_outputs_strobe_n_s;
      clear_prev <= clear_s;
      if (frame_end) begin
        toggle_seen <= toggle_s;
      end
    end
  end

  // frame end events and decode; the captured word is stable after the frame
  assign frame_end = frame_n_s & ~frame_prev;
  assign word_new = frame_end & (toggle_s != toggle_seen);
  assign length_error = frame_end & (toggle_s == toggle_seen);
  assign clear_event = clear_s & ~clear_prev;
  assign load_event = ~load_outputs_strobe_n_s & load_outputs_strobe_prev;
  assign f = frame_s'(link_word);
  assign wr = word_new & (f.dev_addr == addr_s) & ~f.rw;
  assign rd = word_new & (f.dev_addr == addr_s) & f.rw;
  assign sub = f.data[15:13];
  assign wr_code = wr & (f.dreg == DREG_CODE);
  assign wr_gain = wr & (f.dreg == DREG_GAIN);
  assign wr_offset = wr & (f.dreg == DREG_OFFSET);
  assign wr_clear = wr & (f.dreg == DREG_CLEAR);
  assign wr_ctl = wr & (f.dreg == DREG_CONTROL);
  assign soft_hit = wr_ctl & (sub == SUB_SOFT);

  // software register: reset, packet check, watchdog kick
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      soft_rst <= 1'b0;
      watchdog_kick <= 1'b0;
      packet_check <= 1'b0;
    end else begin
      soft_rst <= soft_hit && f.data[11:0] == SOFT_RESET_KEY;
      watchdog_kick <= soft_hit && f.data[11:0] == SOFT_KICK_KEY;
      if (soft_rst) begin
        packet_check <= 1'b0;
      end else if (soft_hit) begin
        packet_check <= f.data[SOFT_PEC_BIT];
      end
    end
  end

  // main and boost control
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      main_control <= '0;
      dcdc_control <= '0;
    end else if (soft_rst) begin
      main_control <= '0;
      dcdc_control <= '0;
    end else begin
      if (wr_ctl && sub == SUB_MAIN) begin
        main_control <= main_ctl_s'(f.data[5:0]);
      end
      if (wr_ctl && sub == SUB_DCDC) begin
        dcdc_control <= dcdc_s'(f.data[5:0]);
      end
    end
  end

  // sticky length error, set wins over the clear by a status read
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      length_flag <= 1'b0;
    end else if (length_error) begin
      length_flag <= 1'b1;
    end else if (rd && f.dreg == DREG_STATUS) begin
      length_flag <= 1'b0;
    end
  end

  assign status_word = {10'h000, length_flag, packet_check, fault_s};

  // readback source select
  always_comb begin
    read_value = 16'h0000;
    unique case (f.dreg)
      DREG_CODE: read_value = code_reg[f.ch];
      DREG_GAIN: read_value = gain_trim[f.ch];
      DREG_OFFSET: read_value = offset_trim[f.ch];
      DREG_CLEAR: read_value = clear_value[f.ch];
      DREG_STATUS: read_value = status_word;
      DREG_CONTROL: begin
        unique case (sub)
          SUB_SLEW: read_value = {3'h0, slew_rate[f.ch]};
          SUB_MAIN: read_value = {10'h000, main_control};
          SUB_CHCTL: read_value = {7'h00, channel_control[f.ch]};
          SUB_DCDC: read_value = {10'h000, dcdc_control};
          default: read_value = {3'h0, packet_check, 12'h000};
        endcase
      end
      default: read_value = 16'h0000;
    endcase
  end

  // readback word for the next frame; status follows writes when selected
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rb_word <= '0;
    end else if (rd) begin
      rb_word <= {1'b0, f.dev_addr, f.dreg, f.ch, read_value};
    end else if (wr && main_control.status_readback) begin
      rb_word <= {1'b0, f.dev_addr, DREG_STATUS, 2'h0, status_word};
    end
  end

  // per channel registers and output path
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic hit;
    assign hit = (f.ch == 2'(ch));

    // trim, code and clear value storage
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        code_reg[ch] <= CODE_RESET;
        gain_trim[ch] <= GAIN_RESET;
        offset_trim[ch] <= OFFSET_RESET;
        clear_value[ch] <= CLEAR_RESET;
      end else if (soft_rst) begin
        code_reg[ch] <= CODE_RESET;
        gain_trim[ch] <= GAIN_RESET;
        offset_trim[ch] <= OFFSET_RESET;
        clear_value[ch] <= CLEAR_RESET;
      end else begin
        if (wr_code && hit) begin
          code_reg[ch] <= f.data;
        end
        if (wr_gain && hit) begin
          gain_trim[ch] <= f.data;
        end
        if (wr_offset && hit) begin
          offset_trim[ch] <= f.data;
        end
        if (wr_clear && hit) begin
          clear_value[ch] <= f.data;
        end
      end
    end

    // channel control and slew rate
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        channel_control[ch] <= CHCTL_RESET;
        slew_rate[ch] <= SLEW_RESET;
      end else if (soft_rst) begin
        channel_control[ch] <= CHCTL_RESET;
        slew_rate[ch] <= SLEW_RESET;
      end else begin
        if (wr_ctl && sub == SUB_CHCTL && hit) begin
          channel_control[ch] <= ch_ctl_s'(f.data[8:0]);
        end
        if (wr_ctl && sub == SUB_SLEW && hit) begin
          slew_rate[ch] <= f.data[12:0];
        end
      end
    end

    // output code: clear wins, then immediate or strobed load
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        channel_output[ch] <= CODE_RESET;
        pending[ch] <= 1'b0;
      end else if (soft_rst) begin
        channel_output[ch] <= CODE_RESET;
        pending[ch] <= 1'b0;
      end else if (clear_event && channel_control[ch].clear_enable) begin
        channel_output[ch] <= clear_value[ch];
        pending[ch] <= 1'b0;
      end else if (wr_code && hit && !load_outputs_strobe_n_s) begin
        channel_output[ch] <= f.data;
        pending[ch] <= 1'b0;
      end else if (wr_code && hit) begin
        pending[ch] <= 1'b1;
      end else if (load_event && pending[ch]) begin
        channel_output[ch] <= code_reg[ch];
        pending[ch] <= 1'b0;
      end
    end

    // calibration pulse and combined enables
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        calibrate_start[ch] <= 1'b0;
        drive_enable[ch] <= 1'b0;
        power_on[ch] <= 1'b0;
      end else begin
        calibrate_start[ch] <= wr_code && hit;
        drive_enable[ch] <= channel_control[ch].output_drive_enable | main_control.all_outputs;
        power_on[ch] <= channel_control[ch].converter_power_bit | main_control.all_power;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  code_cal_a: assert property (wr_code |=> calibrate_start == 4'(1 << $past(f.ch)))
    else $error("code write did not start calibration of its channel");
  soft_clear_a: assert property (soft_rst |=> clear_value == '0 && channel_control[0].range == RANGE_0_5V)
    else $error("reset did not restore clear value or range");
  direct_load_a: assert property (wr_code && !load_outputs_strobe_n_s && !clear_event |=>
    channel_output[$past(f.ch)] == $past(f.data))
    else $error("output not updated at frame end with strobe low");
  strobed_hold_a: assert property (wr_code && load_outputs_strobe_n_s && !clear_event |=> $stable(channel_output))
    else $error("output moved while load strobe was high");
  gain_write_a: assert property (wr_gain |=> gain_trim[$past(f.ch)] == $past(f.data))
    else $error("gain trim write lost");
  offset_write_a: assert property (wr_offset |=> offset_trim[$past(f.ch)] == $past(f.data))
    else $error("offset trim write lost");
  all_outputs_a: assert property (main_control.all_outputs |=> drive_enable == 4'hF)
    else $error("global output enable not applied");
  status_read_a: assert property (rd && f.dreg == DREG_STATUS |=> rb_word[15:0] == $past(status_word))
    else $error("status readback mismatch");
  soft_reset_a: assert property (soft_hit && f.data[11:0] == SOFT_RESET_KEY |=>
    soft_rst ##1 gain_trim[0] == GAIN_RESET)
    else $error("software reset did not restore gain");
  gain_hold_a: assert property (!wr_gain && !soft_rst |=> $stable(gain_trim))
    else $error("gain trim changed without a write");

  code_write_c: cover property (wr_code ##1 calibrate_start != '0);
  strobed_load_c: cover property (load_event && pending != '0);
  clear_apply_c: cover property (clear_event && channel_control[0].clear_enable);
  length_err_c: cover property (length_error);
endmodule
`default_nettype wire

// ===== bench/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the serial link; its clock runs only inside frames
module host_link_model (
  output logic sclk_link,
  output logic frame_select_n,
  output logic sdin,
  input wire logic sdo
);
  // idle link: select high, clock parked low
  initial begin
    sclk_link = 1'b0;
    frame_select_n = 1'b1;
    sdin = 1'b0;
  end

  // one frame of n bits from w, left aligned; readback taken 5 ns after falling edges
  task automatic xfer(input logic [31:0] w, input int n, output logic [23:0] rb);
    rb = '0;
    // offset keeps the link clock phase apart from the system clock
    #3 frame_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      #5 sdin = w[31-i];
      // readback bit 23-k follows falling edge k; taken once settled
      if (i >= 1 && i <= 24) rb[24-i] = sdo;
      #35 sclk_link = 1'b1;
      #40 sclk_link = 1'b0;
    end
    #5;
    if (n == 24) rb[0] = sdo;
    #35 frame_select_n = 1'b1;
    // released data line must not keep showing the last bit
    #5 sdin = ~sdin;
    #200;
  endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dac_regs_pkg::*;
  typedef struct {
    logic [2:0] dreg;
    logic [1:0] ch;
    logic [15:0] d;
    int sel;
    logic [15:0] e;
  } row_s;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic strobe_n = 1'b0;
  logic clear_request = 1'b0;
  logic [1:0] dev = 2'h1;
  logic [3:0] fault_pins = 4'h9;
  wire logic sclk_link;
  wire logic frame_select_n;
  wire logic sdin;
  logic sdo;
  logic [NUM_CH-1:0][15:0] channel_output;
  logic [NUM_CH-1:0][15:0] gain_trim;
  logic [NUM_CH-1:0][15:0] offset_trim;
  ch_ctl_s [NUM_CH-1:0] channel_control;
  logic [NUM_CH-1:0][12:0] slew_rate;
  logic [NUM_CH-1:0] drive_enable;
  logic [NUM_CH-1:0] power_on;
  logic [NUM_CH-1:0] calibrate_start;
  main_ctl_s main_control;
  dcdc_s dcdc_control;
  logic watchdog_kick;
  int bad_count = 0;
  int check_count = 0;
  int cal_cnt = 0;
  int kick_cnt = 0;
  int nb = 24;
  logic [23:0] rb;
  row_s rows[8] = '{
    '{DREG_CODE, 2'h0, 16'h1234, 0, 16'h1234},
    '{DREG_CODE, 2'h3, 16'hFFFF, 0, 16'hFFFF},
    '{DREG_GAIN, 2'h1, 16'h0001, 1, 16'h0001},
    '{DREG_OFFSET, 2'h2, 16'h7FFE, 2, 16'h7FFE},
    '{DREG_CONTROL, 2'h3, {SUB_SLEW, 13'h1ABC}, 4, 16'h1ABC},
    '{DREG_CONTROL, 2'h2, {SUB_CHCTL, 4'h0, 9'h1FF}, 3, 16'h01FF},
    '{DREG_CONTROL, 2'h0, {SUB_MAIN, 7'h0, 6'h36}, 5, 16'h0036},
    '{DREG_CONTROL, 2'h0, {SUB_DCDC, 7'h0, 6'h1B}, 6, 16'h001B}
  };

  always #5 clock = ~clock;

  host_link_model host (
    .sclk_link(sclk_link),
    .frame_select_n(frame_select_n),
    .sdin(sdin),
    .sdo(sdo)
  );

  quad_dac_regs dut (
    .clock(clock),
    .resetn(resetn),
    .sclk_link(sclk_link),
    .frame_select_n(frame_select_n),
    .sdin(sdin),
    .load_outputs_strobe_n(strobe_n),
    .clear_request(clear_request),
    .addr_pins(dev),
    .fault_pins(fault_pins),
    .sdo(sdo),
    .channel_output(channel_output),
    .gain_trim(gain_trim),
    .offset_trim(offset_trim),
    .channel_control(channel_control),
    .slew_rate(slew_rate),
    .drive_enable(drive_enable),
    .power_on(power_on),
    .calibrate_start(calibrate_start),
    .main_control(main_control),
    .dcdc_control(dcdc_control),
    .watchdog_kick(watchdog_kick)
  );

  // pulse counters for calibration and watchdog service, sampled mid-cycle
  always @(negedge clock) begin
    if (calibrate_start[1] === 1'b1) cal_cnt++;
    if (watchdog_kick === 1'b1) kick_cnt++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask

  function automatic logic [23:0] fw(input logic rw, input logic [2:0] dreg, input logic [1:0] ch,
                                     input logic [15:0] d);
    fw = {rw, dev, dreg, ch, d};
  endfunction

  // write frame, then let the decode settle in the system domain
  task automatic wr(input logic [2:0] dreg, input logic [1:0] ch, input logic [15:0] d);
    logic [23:0] r;
    host.xfer({fw(1'b0, dreg, ch, d), 8'h00}, nb, r);
    wt(12);
  endtask

  // read request, answer comes during the following frame
  task automatic rd(input logic [2:0] dreg, input logic [1:0] ch, output logic [23:0] r);
    host.xfer({fw(1'b1, dreg, ch, 16'h0), 8'h00}, nb, r);
    host.xfer({fw(1'b1, DREG_STATUS, 2'h0, 16'h0), 8'h00}, nb, r);
  endtask

  function automatic logic [15:0] got(input int sel, input int c);
    case (sel)
      0: got = channel_output[c];
      1: got = gain_trim[c];
      2: got = offset_trim[c];
      3: got = {7'h0, channel_control[c]};
      4: got = {3'h0, slew_rate[c]};
      5: got = {10'h0, main_control};
      default: got = {10'h0, dcdc_control};
    endcase
  endfunction

  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    report_and_stop();
  end

  initial begin
    wt(10);
    resetn = 1'b1;
    wt(8);
    // power-on defaults
    for (int c = 0; c < NUM_CH; c++) begin
      chk("range", channel_control[c].range, RANGE_0_5V);
      chk("gain", gain_trim[c], GAIN_RESET);
      chk("offset", offset_trim[c], OFFSET_RESET);
      chk("code", channel_output[c], CODE_RESET);
    end
    // table: all writes first, then every value must still hold
    foreach (rows[i]) wr(rows[i].dreg, rows[i].ch, rows[i].d);
    foreach (rows[i]) chk("row", got(rows[i].sel, rows[i].ch), rows[i].e);
    chk("power all", power_on, 4'hF);
    chk("drive all", drive_enable, 4'hF);
    // bring-up: software reset restores defaults
    wr(DREG_CONTROL, 2'h0, {SUB_SOFT, 1'b0, SOFT_RESET_KEY});
    chk("gain after reset", gain_trim[1], GAIN_RESET);
    chk("slew after reset", slew_rate[3], SLEW_RESET);
    wr(DREG_CONTROL, 2'h0, {SUB_DCDC, 7'h0, 6'h24});
    wr(DREG_CONTROL, 2'h1, {SUB_CHCTL, 4'h0, 9'h141});
    chk("power ch1", power_on[1], 1'b1);
    chk("drive ch1 off", drive_enable[1], 1'b0);
    wr(DREG_CODE, 2'h1, 16'hABCD);
    chk("calibration", cal_cnt, 1);
    wt(20000);
    wr(DREG_CONTROL, 2'h1, {SUB_CHCTL, 4'h0, 9'h1C1});
    chk("drive ch1 on", drive_enable[1], 1'b1);
    // strobe held high keeps the code pending until it falls
    strobe_n = 1'b1;
    wr(DREG_CODE, 2'h2, 16'h1111);
    chk("pending", channel_output[2], 16'h0000);
    strobe_n = 1'b0;
    wt(12);
    chk("loaded", channel_output[2], 16'h1111);
    // clear event on enabled channels only
    wr(DREG_CODE, 2'h0, 16'h4321);
    wr(DREG_CLEAR, 2'h2, 16'h5A5A);
    wr(DREG_CONTROL, 2'h0, {SUB_CHCTL, 4'h0, 9'h010});
    wr(DREG_CONTROL, 2'h2, {SUB_CHCTL, 4'h0, 9'h010});
    clear_request = 1'b1;
    wt(8);
    clear_request = 1'b0;
    wt(8);
    chk("clear ch0", channel_output[0], CLEAR_RESET);
    chk("clear ch2", channel_output[2], 16'h5A5A);
    chk("no clear ch1", channel_output[1], 16'hABCD);
    // status readback with faults present
    rd(DREG_STATUS, 2'h0, rb);
    chk("status", rb, {1'b0, dev, DREG_STATUS, 2'h0, 16'h0009});
    // frame for another device address is ignored
    host.xfer({1'b0, ~dev, DREG_CODE, 2'h3, 16'h0F0F, 8'h00}, 24, rb);
    wt(12);
    chk("foreign addr", channel_output[3], 16'h0000);
    // short frame flags a length error
    host.xfer({fw(1'b0, DREG_CODE, 2'h3, 16'h0F0F), 8'h00}, 16, rb);
    wt(12);
    chk("short frame", channel_output[3], 16'h0000);
    rd(DREG_STATUS, 2'h0, rb);
    chk("length flag", rb[5], 1'b1);
    wr(DREG_CONTROL, 2'h0, {SUB_SOFT, 1'b0, SOFT_KICK_KEY});
    chk("kick", kick_cnt, 1);
    // packet checking lengthens frames to 32 bits
    wr(DREG_CONTROL, 2'h0, {SUB_SOFT, 1'b1, 12'h000});
    nb = 32;
    wr(DREG_GAIN, 2'h0, 16'h2468);
    chk("gain 32 bit", gain_trim[0], 16'h2468);
    // status follows each write once readback is selected
    wr(DREG_CONTROL, 2'h0, {SUB_MAIN, 7'h0, 6'h01});
    wr(DREG_GAIN, 2'h1, 16'h1357);
    host.xfer({fw(1'b1, DREG_GAIN, 2'h1, 16'h0), 8'h00}, nb, rb);
    chk("status after write", rb, {1'b0, dev, DREG_STATUS, 2'h0, 16'h0019});
    rd(DREG_STATUS, 2'h0, rb);
    chk("check flag", rb[4], 1'b1);
    // mid-run reset: defaults return and plain frames work again
    resetn = 1'b0;
    wt(3);
    resetn = 1'b1;
    nb = 24;
    wt(8);
    chk("gain mid reset", gain_trim[1], GAIN_RESET);
    chk("range mid reset", channel_control[1].range, RANGE_0_5V);
    wr(DREG_OFFSET, 2'h1, 16'h0102);
    chk("offset after reset", offset_trim[1], 16'h0102);
    rd(DREG_STATUS, 2'h0, rb);
    chk("status after reset", rb, {1'b0, dev, DREG_STATUS, 2'h0, 16'h0009});
    report_and_stop();
  end
endmodule
`default_nettype wire
